// file: hdl/fws_map.vh
`ifndef FWS_MAP_VH
`define FWS_MAP_VH
// ==========================================================
// clock and flash bus timing
`define FWS_CLK_NS 10
`define FWS_T_ACC_NS 70
`define FWS_T_WP_NS 35
`define FWS_T_REC_NS 20
`define FWS_SYNC_CYC 3
// least times round up to whole cycles
`define FWS_ACC_CYC ((`FWS_T_ACC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS + `FWS_SYNC_CYC)
`define FWS_WP_CYC ((`FWS_T_WP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_REC_CYC ((`FWS_T_REC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
// ==========================================================
// register offsets (byte addresses)
`define FWS_REG_CTRL 8'h00
`define FWS_REG_ADDR 8'h04
`define FWS_REG_WDATA 8'h08
`define FWS_REG_STATUS 8'h0C
`define FWS_REG_IRQ_STAT 8'h10
`define FWS_REG_IRQ_MASK 8'h14
// ctrl fields
`define FWS_CTRL_OP_LSB 0
`define FWS_CTRL_SKIP_BIT 4
// operation codes
`define FWS_OP_READ 3'h0
`define FWS_OP_WRITE 3'h1
`define FWS_OP_POLL 3'h2
`define FWS_OP_ERASE_ADD 3'h3
`define FWS_OP_RESET 3'h4
`define FWS_OP_ABORT_RST 3'h5
// result codes
`define FWS_RES_OK 3'h0
`define FWS_RES_TIMEOUT 3'h1
`define FWS_RES_ABORT 3'h2
`define FWS_RES_REJECT 3'h3
`define FWS_RES_MAYBE_REJ 3'h4
// status data bit positions
`define FWS_BIT_POLLING 7
`define FWS_BIT_TOGGLE 6
`define FWS_BIT_TIMEOUT 5
`define FWS_BIT_ERASE_TMR 3
`define FWS_BIT_SECT_TOG 2
`define FWS_BIT_BUF_ABORT 1
// flash command words
`define FWS_CMD_RESET 16'h00F0
`define FWS_CMD_UNLOCK1 16'h00AA
`define FWS_CMD_UNLOCK2 16'h0055
`define FWS_CMD_SECT_ERASE 16'h0030
`define FWS_ADR_UNLOCK1 22'h000555
`define FWS_ADR_UNLOCK2 22'h0002AA
// reset values
`define FWS_RST_CTRL 5'h00
`define FWS_RST_MASK 5'h00
`endif

// file: hdl/fws_cyc.v
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// one asynchronous flash bus cycle, read or write
module fws_cyc (
   // clock and reset
   input wire sys_clk,
   input wire sys_rst,
   // request and answer
   input wire start,
   input wire wr,
   input wire [21:0] addr,
   input wire [15:0] wdata,
   output reg done,
   output reg [15:0] rdata,
   // flash pins
   output reg flash_ce_n,
   output reg flash_oe_n,
   output reg flash_we_n,
   output reg [21:0] flash_addr,
   output reg [15:0] flash_dq_o,
   output reg flash_dq_oe,
   input wire [15:0] flash_dq_i
);
`include "fws_map.vh"

   localparam C_IDLE = 3'd0;
   localparam C_SETUP = 3'd1;
   localparam C_PULSE = 3'd2;
   localparam C_SAMP = 3'd3;
   localparam C_REC = 3'd4;
   // cycle counts cut to the counter width on purpose
   localparam [31:0] ACC_CYC_I = `FWS_ACC_CYC;
   localparam [31:0] WP_CYC_I = `FWS_WP_CYC;
   localparam [31:0] REC_CYC_I = `FWS_REC_CYC;
   localparam [3:0] ACC_CYC = ACC_CYC_I[3:0];
   localparam [3:0] WP_CYC = WP_CYC_I[3:0];
   localparam [3:0] REC_CYC = REC_CYC_I[3:0];

   reg [2:0] st_r;
   reg [3:0] cnt_r;
   reg wr_r;
   reg [15:0] dq1_r, dq2_r, dq3_r;

   // three-stage sampling of the data pins
   always @(posedge sys_clk) begin
      dq1_r <= flash_dq_i;
      dq2_r <= dq1_r;
      dq3_r <= dq2_r;
   end

   // cycle sequencer
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= C_IDLE;
         cnt_r <= 4'h0;
         wr_r <= 1'b0;
         done <= 1'b0;
         rdata <= 16'h0000;
         flash_ce_n <= 1'b1;
         flash_oe_n <= 1'b1;
         flash_we_n <= 1'b1;
         flash_addr <= 22'h000000;
         flash_dq_o <= 16'h0000;
         flash_dq_oe <= 1'b0;
      end else begin
         done <= 1'b0;
         case (st_r)
            C_IDLE: begin
               if (start) begin
                  wr_r <= wr;
                  flash_addr <= addr;
                  flash_dq_o <= wdata;
                  flash_dq_oe <= wr;
                  flash_ce_n <= 1'b0;
                  st_r <= C_SETUP;
               end
            end
            C_SETUP: begin
               flash_oe_n <= wr_r;
               flash_we_n <= ~wr_r;
               cnt_r <= wr_r ? WP_CYC : ACC_CYC;
               st_r <= C_PULSE;
            end
            C_PULSE: begin
               if (cnt_r > 4'h1) begin
                  cnt_r <= cnt_r - 4'h1;
               end else if (wr_r) begin
                  flash_we_n <= 1'b1;
                  flash_ce_n <= 1'b1;
                  cnt_r <= REC_CYC;
                  st_r <= C_REC;
               end else begin
                  st_r <= C_SAMP;
               end
            end
            C_SAMP: begin
               // take data once the last two stages agree
               if (dq2_r == dq3_r) begin
                  rdata <= dq3_r;
                  flash_oe_n <= 1'b1;
                  flash_ce_n <= 1'b1;
                  cnt_r <= REC_CYC;
                  st_r <= C_REC;
               end
            end
            C_REC: begin
               flash_dq_oe <= 1'b0;
               if (cnt_r > 4'h1) begin
                  cnt_r <= cnt_r - 4'h1;
               end else begin
                  done <= 1'b1;
                  st_r <= C_IDLE;
               end
            end
            default: st_r <= C_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// file: hdl/fws_host.v
// How it works
// (RULE1) device sets timeout flag when an operation overruns its pulse limit
// (RULE2) programming a 1 over a 0 may halt and end in timeout flag
// (RULE3) programming only clears bits; only erase sets them back to 1
// (RULE4) after timeout host writes reset command; device returns to read
// (RULE5) erase timer flag 0 during acceptance window, 1 after; restarts per sector
// (RULE6) host may skip erase timer checks if sector commands come under 50 us
// (RULE7) with erase timer flag 1 only suspend is accepted; with 0 more sectors
// (RULE8) host checks erase timer flag before and after each added sector
// (RULE9) buffer abort flag set on abort; host issues abort-reset sequence
// (RULE10) polling and sector toggle reads use programmed or erasing-sector address
// (RULE11) write-buffer polling uses the last loaded buffer address
// (RULE12) ready_busy_n low while program or erase runs, high otherwise
// (RULE13) toggle bit inverts each read while busy, stops when finished
// (RULE14) while busy, reads return status bits instead of array data
`timescale 1ns/100ps
`default_nettype none
module fws_host (
   // clock and reset
   input wire sys_clk,
   input wire sys_rst,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [7:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   // interrupt
   output reg irq,
   // flash pins
   output wire flash_ce_n,
   output wire flash_oe_n,
   output wire flash_we_n,
   output wire [21:0] flash_addr,
   output wire [15:0] flash_dq_o,
   output wire flash_dq_oe,
   input wire [15:0] flash_dq_i,
   input wire ready_busy_n
);
`include "fws_map.vh"

   localparam S_IDLE = 4'd0;
   localparam S_RD = 4'd1;
   localparam S_WR = 4'd2;
   localparam S_P1 = 4'd3;
   localparam S_P2 = 4'd4;
   localparam S_P3 = 4'd5;
   localparam S_P4 = 4'd6;
   localparam S_SEQ = 4'd7;
   localparam S_E1 = 4'd8;
   localparam S_E2 = 4'd9;
   localparam S_E3 = 4'd10;

   // ==========================================================
   // command sequences: kind 0 reset, kind 1 abort-reset
   function [1:0] seq_last;
      input kind;
      seq_last = kind ? 2'd2 : 2'd0;
   endfunction

   function [21:0] seq_addr;
      input kind;
      input [1:0] idx;
      seq_addr = (kind && idx == 2'd1) ? `FWS_ADR_UNLOCK2 : `FWS_ADR_UNLOCK1;
   endfunction

   function [15:0] seq_data;
      input kind;
      input [1:0] idx;
      if (!kind || idx == 2'd2) begin
         seq_data = `FWS_CMD_RESET;
      end else if (idx == 2'd0) begin
         seq_data = `FWS_CMD_UNLOCK1;
      end else begin
         seq_data = `FWS_CMD_UNLOCK2;
      end
   endfunction

   // ==========================================================
   // registers and state
   reg [4:0] ctrl_r;
   reg [21:0] addr_r;
   reg [15:0] wdata_r;
   reg [4:0] stat_r;
   reg [4:0] mask_r;
   reg start_r;
   reg [3:0] st_r;
   reg [2:0] res_r;
   reg fin_r;
   reg [15:0] last_r;
   reg [15:0] first_r;
   reg seq_kind_r;
   reg [1:0] seq_idx_r;
   reg go_r;
   reg go_wr_r;
   reg [21:0] go_addr_r;
   reg [15:0] go_data_r;
   reg rb1_r, rb2_r, rb3_r, rb_r, rb_rise_r;
   wire cyc_done;
   wire [15:0] cyc_rdata;
   wire busy;
   wire acc;
   wire hit;
   wire [4:0] ev;
   wire [4:0] stat_nxt;
   wire [2:0] op;
   wire skip;

   assign busy = (st_r != S_IDLE) | start_r;
   assign acc = psel & penable & pready;
   assign op = ctrl_r[`FWS_CTRL_OP_LSB +: 3];
   assign skip = ctrl_r[`FWS_CTRL_SKIP_BIT];
   assign hit = (paddr == `FWS_REG_CTRL) | (paddr == `FWS_REG_ADDR) | (paddr == `FWS_REG_WDATA) |
                (paddr == `FWS_REG_STATUS) | (paddr == `FWS_REG_IRQ_STAT) | (paddr == `FWS_REG_IRQ_MASK);

   // ==========================================================
   // bus cycle engine
   fws_cyc u_cyc (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .start(go_r),
      .wr(go_wr_r),
      .addr(go_addr_r),
      .wdata(go_data_r),
      .done(cyc_done),
      .rdata(cyc_rdata),
      .flash_ce_n(flash_ce_n),
      .flash_oe_n(flash_oe_n),
      .flash_we_n(flash_we_n),
      .flash_addr(flash_addr),
      .flash_dq_o(flash_dq_o),
      .flash_dq_oe(flash_dq_oe),
      .flash_dq_i(flash_dq_i)
   );

   // ready/busy pin: three flops, level taken when last two agree
   always @(posedge sys_clk) begin
      rb1_r <= ready_busy_n;
      rb2_r <= rb1_r;
      rb3_r <= rb2_r;
      if (sys_rst) begin
         rb_r <= 1'b1;
         rb_rise_r <= 1'b0;
      end else begin
         rb_rise_r <= (rb2_r == rb3_r) & rb3_r & ~rb_r; // RULE12
         if (rb2_r == rb3_r) begin
            rb_r <= rb3_r;
         end
      end
   end

   // ==========================================================
   // interrupt events: done, timeout, abort, erase reject, ready rise
   assign ev = {rb_rise_r,
                fin_r & ((res_r == `FWS_RES_REJECT) | (res_r == `FWS_RES_MAYBE_REJ)),
                fin_r & (res_r == `FWS_RES_ABORT),
                fin_r & (res_r == `FWS_RES_TIMEOUT),
                fin_r};
   // set wins over write-one-to-clear
   assign stat_nxt = (stat_r & ~((acc & pwrite & (paddr == `FWS_REG_IRQ_STAT)) ? pwdata[4:0] : 5'h00)) | ev;

   // apb slave: no wait states, registered answer
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         ctrl_r <= `FWS_RST_CTRL;
         addr_r <= 22'h000000;
         wdata_r <= 16'h0000;
         mask_r <= `FWS_RST_MASK;
         stat_r <= 5'h00;
         start_r <= 1'b0;
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
         irq <= 1'b0;
      end else begin
         pready <= psel & ~penable & ~pready;
         pslverr <= psel & ~penable & ~pready & ~hit;
         stat_r <= stat_nxt;
         irq <= |(stat_nxt & mask_r);
         start_r <= 1'b0;
         if (psel & ~penable & ~pready) begin
            case (paddr)
               `FWS_REG_CTRL: prdata <= {27'h0000000, ctrl_r};
               `FWS_REG_ADDR: prdata <= {10'h000, addr_r};
               `FWS_REG_WDATA: prdata <= {16'h0000, wdata_r};
               `FWS_REG_STATUS: prdata <= {last_r, 11'h000, res_r, rb_r, busy};
               `FWS_REG_IRQ_STAT: prdata <= {27'h0000000, stat_r};
               `FWS_REG_IRQ_MASK: prdata <= {27'h0000000, mask_r};
               default: prdata <= 32'h00000000;
            endcase
         end
         if (acc & pwrite) begin
            case (paddr)
               `FWS_REG_CTRL: begin
                  // a command written while busy is dropped
                  if (!busy) begin
                     ctrl_r <= pwdata[4:0];
                     start_r <= 1'b1;
                  end
               end
               `FWS_REG_ADDR: addr_r <= pwdata[21:0];
               `FWS_REG_WDATA: wdata_r <= pwdata[15:0];
               `FWS_REG_IRQ_MASK: mask_r <= pwdata[4:0];
               default: ;
            endcase
         end
      end
   end

   // ==========================================================
   // operation sequencer
   always @(posedge sys_clk) begin
      if (sys_rst) begin
         st_r <= S_IDLE;
         res_r <= `FWS_RES_OK;
         fin_r <= 1'b0;
         last_r <= 16'h0000;
         first_r <= 16'h0000;
         seq_kind_r <= 1'b0;
         seq_idx_r <= 2'd0;
         go_r <= 1'b0;
         go_wr_r <= 1'b0;
         go_addr_r <= 22'h000000;
         go_data_r <= 16'h0000;
      end else begin
         go_r <= 1'b0;
         fin_r <= 1'b0;
         if (cyc_done) begin
            last_r <= cyc_rdata;
         end
         case (st_r)
            S_IDLE: begin
               if (start_r) begin
                  go_r <= 1'b1;
                  go_addr_r <= addr_r; // RULE10 RULE11
                  go_data_r <= wdata_r;
                  go_wr_r <= 1'b0;
                  res_r <= `FWS_RES_OK;
                  seq_idx_r <= 2'd0;
                  case (op)
                     `FWS_OP_READ: st_r <= S_RD;
                     `FWS_OP_WRITE: begin
                        go_wr_r <= 1'b1;
                        st_r <= S_WR;
                     end
                     `FWS_OP_POLL: st_r <= S_P1;
                     `FWS_OP_ERASE_ADD: begin
                        if (skip) begin
                           go_wr_r <= 1'b1; // RULE6
                           go_data_r <= `FWS_CMD_SECT_ERASE;
                           st_r <= S_E2;
                        end else begin
                           st_r <= S_E1;
                        end
                     end
                     `FWS_OP_RESET, `FWS_OP_ABORT_RST: begin
                        seq_kind_r <= (op == `FWS_OP_ABORT_RST);
                        go_go_seq(op);
                     end
                     default: begin
                        go_r <= 1'b0;
                        fin_r <= 1'b1;
                     end
                  endcase
               end
            end
            S_RD, S_WR: begin
               if (cyc_done) begin
                  fin_r <= 1'b1;
                  st_r <= S_IDLE;
               end
            end
            // toggle algorithm: two reads, compare toggle bit
            S_P1, S_P3: begin
               if (cyc_done) begin
                  first_r <= cyc_rdata;
                  go_r <= 1'b1;
                  st_r <= (st_r == S_P1) ? S_P2 : S_P4;
               end
            end
            S_P2: begin
               if (cyc_done) begin
                  go_r <= 1'b1;
                  if (cyc_rdata[`FWS_BIT_TOGGLE] == first_r[`FWS_BIT_TOGGLE]) begin
                     go_r <= 1'b0; // RULE13 RULE14
                     fin_r <= 1'b1;
                     st_r <= S_IDLE;
                  end else if (cyc_rdata[`FWS_BIT_BUF_ABORT]) begin
                     res_r <= `FWS_RES_ABORT; // RULE9
                     seq_kind_r <= 1'b1;
                     go_wr_r <= 1'b1;
                     go_addr_r <= seq_addr(1'b1, 2'd0);
                     go_data_r <= seq_data(1'b1, 2'd0);
                     st_r <= S_SEQ;
                  end else begin
                     // timeout flag seen: recheck, toggle may just have stopped
                     st_r <= cyc_rdata[`FWS_BIT_TIMEOUT] ? S_P3 : S_P1; // RULE1 RULE2
                  end
               end
            end
            S_P4: begin
               if (cyc_done) begin
                  if (cyc_rdata[`FWS_BIT_TOGGLE] == first_r[`FWS_BIT_TOGGLE]) begin
                     fin_r <= 1'b1;
                     st_r <= S_IDLE;
                  end else begin
                     res_r <= `FWS_RES_TIMEOUT; // RULE4
                     seq_kind_r <= 1'b0;
                     go_r <= 1'b1;
                     go_wr_r <= 1'b1;
                     go_addr_r <= seq_addr(1'b0, 2'd0);
                     go_data_r <= seq_data(1'b0, 2'd0);
                     st_r <= S_SEQ;
                  end
               end
            end
            S_SEQ: begin
               if (cyc_done) begin
                  if (seq_idx_r == seq_last(seq_kind_r)) begin
                     fin_r <= 1'b1;
                     st_r <= S_IDLE;
                  end else begin
                     go_r <= 1'b1;
                     go_addr_r <= seq_addr(seq_kind_r, seq_idx_r + 2'd1);
                     go_data_r <= seq_data(seq_kind_r, seq_idx_r + 2'd1);
                     seq_idx_r <= seq_idx_r + 2'd1;
                  end
               end
            end
            // added sector: check erase timer flag before and after
            S_E1: begin
               if (cyc_done) begin
                  if (cyc_rdata[`FWS_BIT_ERASE_TMR]) begin
                     res_r <= `FWS_RES_REJECT; // RULE7 RULE8
                     fin_r <= 1'b1;
                     st_r <= S_IDLE;
                  end else begin
                     go_r <= 1'b1;
                     go_wr_r <= 1'b1;
                     go_data_r <= `FWS_CMD_SECT_ERASE; // RULE5
                     st_r <= S_E2;
                  end
               end
            end
            S_E2: begin
               if (cyc_done) begin
                  if (skip) begin
                     fin_r <= 1'b1;
                     st_r <= S_IDLE;
                  end else begin
                     go_r <= 1'b1;
                     go_wr_r <= 1'b0;
                     st_r <= S_E3;
                  end
               end
            end
            S_E3: begin
               if (cyc_done) begin
                  if (cyc_rdata[`FWS_BIT_ERASE_TMR]) begin
                     res_r <= `FWS_RES_MAYBE_REJ; // RULE8
                  end
                  fin_r <= 1'b1;
                  st_r <= S_IDLE;
               end
            end
            default: st_r <= S_IDLE;
         endcase
      end
   end

   // start a reset or abort-reset sequence from idle
   task go_go_seq;
      input [2:0] o;
      begin
         go_wr_r <= 1'b1;
         go_addr_r <= seq_addr(o == `FWS_OP_ABORT_RST, 2'd0);
         go_data_r <= seq_data(o == `FWS_OP_ABORT_RST, 2'd0);
         st_r <= S_SEQ;
      end
   endtask
endmodule
`default_nettype wire

// file: tb/fws_host_sva.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// port checker for the flash status host
module fws_host_sva (
   // clock and reset
   input wire sys_clk,
   input wire sys_rst,
   // apb
   input wire psel,
   input wire penable,
   input wire pready,
   input wire pslverr,
   // flash pins
   input wire flash_ce_n,
   input wire flash_oe_n,
   input wire flash_we_n,
   input wire [21:0] flash_addr,
   input wire flash_dq_oe
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);
   // apb answer timing
   AST_APB_ACCESS: assert property (psel && !penable |=> pready)
      else $error("no answer one cycle after setup");
   AST_READY_IN_ACCESS: assert property (pready |-> psel && penable)
      else $error("ready outside access phase");
   AST_ERR_WITH_READY: assert property (pslverr |-> pready)
      else $error("error without ready");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready longer than one cycle");
   // flash strobe shapes
   AST_WE_WIDTH: assert property ($fell(flash_we_n) |-> !flash_we_n [*4] ##1 flash_we_n)
      else $error("write strobe not four cycles");
   AST_OE_WIDTH: assert property ($fell(flash_oe_n) |-> !flash_oe_n [*8])
      else $error("output enable too short");
   AST_NO_CLASH: assert property (flash_dq_oe |-> flash_oe_n)
      else $error("host drives data while flash outputs");
   AST_ADDR_HOLD: assert property (!flash_ce_n && !$past(flash_ce_n) |-> $stable(flash_addr))
      else $error("address moved inside a cycle");
   AST_IDLE_GAP: assert property ($rose(flash_ce_n) |-> flash_ce_n [*2])
      else $error("idle gap under two cycles");
   AST_STROBE_SEL: assert property (!(flash_oe_n && flash_we_n) |-> !flash_ce_n)
      else $error("strobe without chip select");
endmodule
bind fws_host fws_host_sva u_sva (.*);
`default_nettype wire

// file: tb/fws_flash_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// behavioural flash with write status reporting
module fws_flash_model (
   // clock
   input wire sys_clk,
   // flash pins
   input wire flash_ce_n,
   input wire flash_oe_n,
   input wire flash_we_n,
   input wire [21:0] flash_addr,
   input wire [15:0] flash_dq_o,
   output wire [15:0] flash_dq_i,
   output wire ready_busy_n,
   // scenario control
   input wire load,
   input wire [7:0] n_reads,
   input wire tmo,
   input wire abt,
   input wire et_on_cmd,
   output reg [7:0] sect_cnt = 8'h00
);
   reg [15:0] mem [0:15];
   reg [15:0] rd_r = 16'h0000;
   reg [7:0] cnt_r = 8'h00;
   reg tf_r = 0, af_r = 0, et_r = 0, tog_r = 0, oe_q = 1, we_q = 1;
   reg [1:0] unl_r = 2'h0;
   wire [3:0] a = flash_addr[3:0];
   wire busy = cnt_r != 8'h00 || tf_r || af_r;
   integer i;
   // array starts erased
   initial begin
      for (i = 0; i < 16; i = i + 1) mem[i] = 16'hFFFF;
   end
   // released bus shows inverse of last data
   assign flash_dq_i = (!flash_ce_n && !flash_oe_n) ? rd_r : ~rd_r;
   assign ready_busy_n = !busy;
   // read and write cycle handling
   always @(posedge sys_clk) begin
      oe_q <= flash_oe_n;
      we_q <= flash_we_n;
      if (load) begin
         cnt_r <= n_reads;
         tf_r <= tmo;
         af_r <= abt;
         et_r <= 0;
      end
      if (oe_q && !flash_oe_n && !flash_ce_n) begin
         if (busy) begin
            tog_r <= ~tog_r;
            rd_r <= {8'h00, ~mem[a][7], ~tog_r, tf_r, 1'b0, et_r, ~tog_r, af_r, 1'b0};
            if (!tf_r && !af_r) cnt_r <= cnt_r - 8'h01;
         end else rd_r <= mem[a];
      end
      if (!we_q && flash_we_n && !(et_r && busy)) begin
         unl_r <= 2'h0;
         if (flash_dq_o[7:0] == 8'hF0) begin
            tf_r <= 0;
            cnt_r <= 8'h00; // reset command ends the embedded operation
            if (unl_r == 2'h2) af_r <= 0;
         end else if (flash_dq_o[7:0] == 8'hAA && flash_addr == 22'h000555) unl_r <= 2'h1;
         else if (flash_dq_o[7:0] == 8'h55 && flash_addr == 22'h0002AA && unl_r == 2'h1) unl_r <= 2'h2;
         else if (flash_dq_o[7:0] == 8'h30) begin
            sect_cnt <= sect_cnt + 8'h01;
            et_r <= et_on_cmd;
         end else if (!busy) mem[a] <= mem[a] & flash_dq_o;
      end
   end
endmodule
`default_nettype wire

// file: tb/test_fws_host.sv
`timescale 1ns/100ps
`default_nettype none
// ==========================================================
// register level test of the flash status host
module test_fws_host;
   reg sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
   reg [7:0] paddr = 8'h00;
   reg [31:0] pwdata = 32'h00000000;
   wire [31:0] prdata;
   wire pready, pslverr, irq, flash_ce_n, flash_oe_n, flash_we_n, flash_dq_oe, ready_busy_n;
   wire [21:0] flash_addr;
   wire [15:0] flash_dq_o, flash_dq_i;
   reg load = 0, tmo = 0, abt = 0, et_on_cmd = 0;
   reg [7:0] n_reads = 8'h00;
   wire [7:0] sect_cnt;
   reg [31:0] rd;
   reg err;
   integer miscompares = 0, samples_checked = 0;
   fws_host uut (.*);
   fws_flash_model u_flash (.*);
   // ==========================================================
   // clock
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end
   // ==========================================================
   // tasks
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", samples_checked, miscompares);
         if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
         else $display("Run complete: FAIL");
         $finish;
      end
   endtask
   task chk(input [95:0] nm, input [31:0] e, input [31:0] g);
      begin
         samples_checked = samples_checked + 1;
         if (g !== e) begin
            miscompares = miscompares + 1;
            $display("MISMATCH %0s exp %h got %h", nm, e, g);
         end
      end
   endtask
   task apb(input w, input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge sys_clk);
         psel <= 1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge sys_clk);
         penable <= 1;
         n = 0;
         @(posedge sys_clk);
         while (pready !== 1'b1) begin
            n = n + 1;
            if (n > 20) begin
               chk("apb_wait", 0, 1);
               print_verdict;
            end
            @(posedge sys_clk);
         end
         // answer and release at the same rising edge
         rd = prdata;
         err = pslverr;
         psel <= 0;
         penable <= 0;
      end
   endtask
   task run(input [7:0] ctl, input [2:0] res);
      integer n;
      begin
         apb(1, 8'h00, {24'h0, ctl});
         n = 0;
         rd = 1;
         while (rd[0] !== 1'b0) begin
            n = n + 1;
            if (n > 2000) begin
               chk("op_wait", 0, 1);
               print_verdict;
            end
            apb(0, 8'h0C, 0);
         end
         chk("result", res, rd[4:2]);
         repeat (5) @(posedge sys_clk);
      end
   endtask
   task arm(input [7:0] n, input t, input b);
      begin
         @(posedge sys_clk);
         load <= 1;
         n_reads <= n;
         tmo <= t;
         abt <= b;
         @(posedge sys_clk);
         load <= 0;
         // let the ready pin pass the host's three-stage sampler
         repeat (5) @(posedge sys_clk);
      end
   endtask
   task chk_irq(input e);
      begin
         @(negedge sys_clk);
         chk("irq", e, irq);
      end
   endtask
   // ==========================================================
   // test sequence
   initial begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 0;
      apb(0, 8'h00, 0);
      chk("ctrl", 0, rd);
      apb(0, 8'h14, 0);
      chk("mask", 0, rd);
      apb(0, 8'h18, 32'h5);
      chk("unmap_err", 1, err);
      chk("unmap_dat", 0, rd);
      $display("test reset done");
      apb(1, 8'h04, 32'h123);
      apb(1, 8'h08, 32'h0F0F);
      run(8'h01, 3'h0);
      apb(1, 8'h08, 32'hF0FF);
      run(8'h01, 3'h0);
      run(8'h00, 3'h0);
      chk("array", 32'h000F, rd[31:16]);
      $display("test program done");
      apb(1, 8'h14, 32'h11);
      apb(1, 8'h10, 32'h1F);
      arm(8'h04, 0, 0);
      apb(0, 8'h0C, 0);
      chk("busy_pin", 0, rd[1]);
      run(8'h02, 3'h0);
      apb(0, 8'h0C, 0);
      chk("ready_pin", 1, rd[1]);
      apb(0, 8'h10, 0);
      chk("irq_stat", 32'h11, rd);
      chk_irq(1);
      apb(1, 8'h10, 32'h11);
      chk_irq(0);
      $display("test poll done");
      apb(1, 8'h14, 32'h02);
      arm(8'h01, 1, 0);
      run(8'h02, 3'h1);
      apb(0, 8'h0C, 0);
      chk("tmo_ready", 1, rd[1]);
      chk_irq(1);
      apb(1, 8'h10, 32'h1F);
      chk_irq(0);
      $display("test timeout done");
      apb(1, 8'h14, 32'h04);
      arm(8'h01, 0, 1);
      run(8'h02, 3'h2);
      apb(0, 8'h0C, 0);
      chk("abt_ready", 1, rd[1]);
      chk_irq(1);
      apb(1, 8'h10, 32'h1F);
      $display("test abort done");
      arm(8'h14, 0, 0);
      apb(1, 8'h04, 32'h40);
      run(8'h03, 3'h0);
      chk("sectors", 1, sect_cnt);
      et_on_cmd <= 1;
      run(8'h03, 3'h4);
      chk("sectors", 2, sect_cnt);
      run(8'h03, 3'h3);
      chk("sectors", 2, sect_cnt);
      apb(0, 8'h10, 0);
      chk("rej_stat", 1, rd[3]);
      run(8'h13, 3'h0);
      chk("sectors", 2, sect_cnt);
      run(8'h00, 3'h0);
      chk("busy_read", 32'h08, rd[23:16] & 8'h2B);
      $display("test erase done");
      print_verdict;
   end
endmodule
`default_nettype wire
